/* File: core/adc_pin_pkg.sv */
// Constants shared by the converter's pin control logic.
// Assumes the three-level pins arrive already resolved into 2-bit codes.
package adc_pin_pkg;

  // ==========================================================
  // Three-level pin codes
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_MID  = 2'h2;

  // ==========================================================
  // Serial configuration frame: address then data, MSB first
  localparam int         CFG_ADDR_W   = 4;
  localparam int         CFG_DATA_W   = 16;
  localparam int         FRAME_BITS   = CFG_ADDR_W + CFG_DATA_W;
  localparam int         FRAME_CNT_W  = 5;
  localparam logic [FRAME_CNT_W-1:0] FRAME_LEN = 5'h14;
  localparam logic [CFG_ADDR_W-1:0] CFG_ADDR_CONFIG = 4'h1;
  localparam int         SYNC_SRC_BIT = 14;
  localparam logic [CFG_DATA_W-1:0] CFG_RESET = 16'h0000;

  // ==========================================================
  // Calibration timing
  localparam int         CAL_MIN_CYCLES = 80;
  localparam int         CAL_CNT_W      = 16;
  localparam logic [CAL_CNT_W-1:0] CNT_ONE = 16'h0001;

  // ==========================================================
  // State machines, one-bit steps except those between idle and run or drain
  typedef enum logic [1:0] {
    CAL_IDLE  = 2'h0,
    CAL_DELAY = 2'h1,
    CAL_RUN   = 2'h3
  } cal_state_t;

  typedef enum logic [1:0] {
    CAP_IDLE  = 2'h0,
    CAP_FILL  = 2'h1,
    CAP_DRAIN = 2'h3
  } cap_state_t;

endpackage

/* File: core/cal_request_filter.sv */
// Qualifies the calibration request pin: a long low then a long high.
// Assumes the pin is synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module cal_request_filter #(
  parameter int MIN_CYCLES = adc_pin_pkg::CAL_MIN_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cal_request,
  output logic      cal_go
);

  localparam int CW = $clog2(MIN_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYCLES);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_INC = CW'(1);

  logic [CW-1:0] low_cnt_q;
  logic [CW-1:0] high_cnt_q;
  logic          armed_q;

  // ==========================================================
  // Low phase counter, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q <= CNT_ZERO;
    end else if (cal_request) begin
      low_cnt_q <= CNT_ZERO;
    end else if (low_cnt_q != CNT_MAX) begin
      low_cnt_q <= low_cnt_q + CNT_INC;
    end
  end

  // Armed once the low phase is long enough; a short low never arms
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (!cal_request) begin
      armed_q <= (low_cnt_q + CNT_INC >= CNT_MAX);
    end else if (cal_go) begin
      armed_q <= 1'b0;
    end
  end

  // High phase counter; a short high drops back to low counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt_q <= CNT_ZERO;
    end else if (!cal_request || !armed_q) begin
      high_cnt_q <= CNT_ZERO;
    end else if (high_cnt_q != CNT_MAX) begin
      high_cnt_q <= high_cnt_q + CNT_INC;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_go <= 1'b0;
    end else begin
      cal_go <= armed_q && cal_request && !cal_go
                && (high_cnt_q + CNT_INC == CNT_MAX);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_go_after_high: assert property (cal_go |-> $past(cal_request, 1))
    else $error("calibration start without high request level");
  a_short_high: assert property (
    (armed_q && !cal_request) |=> !cal_go)
    else $error("calibration start after a dropped high phase");
  a_go_single: assert property (cal_go |=> !cal_go)
    else $error("calibration start longer than one cycle");
  c_go_seen: cover property (cal_go);

endmodule
`default_nettype wire

/* File: core/adc_control_pin_logic.sv */
// Pin control logic of the 8-bit converter with its capture buffer.
// Assumes all pin inputs are synchronous to clk; three-level pins come in
// pre-resolved as low, high or mid codes.
//
// What this block does
// - Serial clock shifts configuration data in extended mode
// - Firm edge pin level picks output edge
// - Floating edge pin selects double data rate
// - Edge pin is serial data in extended mode
// - Reset pulse restarts sample clock for sync
// - Config bit 14 clear selects single-ended reset
// - Power down high; capture buffer keeps running
// - Long low then long high starts calibration
// - Samples stored and shown as offset binary
// - 4K buffer drains over two 8-bit buses
// - Floating range pin enables extended control mode
// - Extended mode: delay pin selects, short delay
// - Calibration running output high throughout calibration
// - Config bit 14 set selects differential reset
`timescale 1ns/10ps
`default_nettype none
module adc_control_pin_logic #(
  parameter int DEPTH           = 4096,
  parameter int CAL_DLY_SHORT   = 1024,
  parameter int CAL_DLY_LONG    = 40000,
  parameter int CAL_RUN_CYCLES  = 1400
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] output_edge_select,
  input  wire logic [1:0] range_or_extended_enable,
  input  wire logic       cal_delay_or_serial_select,
  input  wire logic       serial_clock,
  input  wire logic       sample_clock_sync_reset,
  input  wire logic       sample_clock_sync_reset_pos,
  input  wire logic       sample_clock_sync_reset_neg,
  input  wire logic       power_down_request,
  input  wire logic       calibration_request,
  input  wire logic [7:0] sample_in,
  input  wire logic       sample_valid,
  input  wire logic       capture_start,
  output logic            extended_mode,
  output logic            edge_rising,
  output logic            ddr_mode,
  output logic            range_high,
  output logic            power_down_active,
  output logic            calibration_running,
  output logic            sample_clock_reset,
  output logic            sample_phase,
  output logic            capture_busy,
  output logic            output_data_strobe,
  output logic [7:0]      bus_a,
  output logic [7:0]      bus_b,
  output logic [15:0]     config_word
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [AW-1:0] PTR_TWO  = AW'(2);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] PTR_PAIR_LAST = AW'(DEPTH - 2);
  localparam int CW = adc_pin_pkg::CAL_CNT_W;
  localparam logic [CW-1:0] DLY_SHORT = CW'(CAL_DLY_SHORT);
  localparam logic [CW-1:0] DLY_LONG  = CW'(CAL_DLY_LONG);
  localparam logic [CW-1:0] RUN_LEN   = CW'(CAL_RUN_CYCLES);
  localparam int FW = adc_pin_pkg::FRAME_CNT_W;

  // ==========================================================
  // Mode decode from static pin levels
  logic ext_now;
  logic serial_config_input;
  logic serial_select_active;
  assign ext_now = (range_or_extended_enable == adc_pin_pkg::LVL_MID);
  assign serial_config_input =
    (output_edge_select == adc_pin_pkg::LVL_HIGH);
  assign serial_select_active = ext_now && !cal_delay_or_serial_select;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extended_mode <= 1'b0;
      edge_rising   <= 1'b0;
      ddr_mode      <= 1'b0;
      range_high    <= 1'b0;
    end else begin
      extended_mode <= ext_now;
      if (!ext_now) begin
        // Extended mode keeps the last normal-mode output settings
        ddr_mode    <= (output_edge_select == adc_pin_pkg::LVL_MID);
        edge_rising <= (output_edge_select == adc_pin_pkg::LVL_HIGH);
        range_high  <= (range_or_extended_enable == adc_pin_pkg::LVL_HIGH);
      end
    end
  end

  // ==========================================================
  // Serial configuration port
  logic                                serial_clock_prev_q;
  logic                                serial_rise;
  logic                                select_prev_q;
  logic [adc_pin_pkg::FRAME_BITS-1:0]  shift_q;
  logic [FW-1:0]                       bit_cnt_q;

  assign serial_rise = serial_clock && !serial_clock_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_clock_prev_q <= 1'b0;
      select_prev_q       <= 1'b0;
    end else begin
      serial_clock_prev_q <= serial_clock;
      select_prev_q       <= serial_select_active;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q   <= '0;
      bit_cnt_q <= '0;
    end else if (!serial_select_active) begin
      bit_cnt_q <= '0;
    end else if (serial_rise && bit_cnt_q != adc_pin_pkg::FRAME_LEN) begin
      // Bits past the frame length are dropped, not wrapped
      shift_q   <= {shift_q[adc_pin_pkg::FRAME_BITS-2:0],
                    serial_config_input};
      bit_cnt_q <= bit_cnt_q + FW'(1);
    end
  end

  // Written only on a whole frame at select release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_word <= adc_pin_pkg::CFG_RESET;
    end else if (select_prev_q && !serial_select_active
                 && bit_cnt_q == adc_pin_pkg::FRAME_LEN
                 && shift_q[adc_pin_pkg::FRAME_BITS-1 -: adc_pin_pkg::CFG_ADDR_W]
                    == adc_pin_pkg::CFG_ADDR_CONFIG) begin
      config_word <= shift_q[adc_pin_pkg::CFG_DATA_W-1:0];
    end
  end

  // ==========================================================
  // Sample clock synchronising reset
  logic sync_src;
  logic sync_src_prev_q;
  assign sync_src = config_word[adc_pin_pkg::SYNC_SRC_BIT]
                  ? (sample_clock_sync_reset_pos
                     && !sample_clock_sync_reset_neg)
                  : sample_clock_sync_reset;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_src_prev_q    <= 1'b0;
      sample_clock_reset <= 1'b0;
      sample_phase       <= 1'b0;
    end else begin
      sync_src_prev_q    <= sync_src;
      sample_clock_reset <= sync_src && !sync_src_prev_q;
      // Interleave phase restarts so that all devices line up
      sample_phase       <= (sync_src && !sync_src_prev_q)
                            ? 1'b0 : !sample_phase;
    end
  end

  // ==========================================================
  // Power down; the capture buffer is deliberately not gated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_down_active <= 1'b0;
    end else begin
      power_down_active <= power_down_request;
    end
  end

  // ==========================================================
  // Calibration: after reset, and on a qualified request
  logic                    cal_go;
  adc_pin_pkg::cal_state_t cal_st_q;
  logic [CW-1:0]           cal_cnt_q;

  cal_request_filter #(
    .MIN_CYCLES (adc_pin_pkg::CAL_MIN_CYCLES)
  ) u_cal_filter (
    .clk         (clk),
    .rst_n       (rst_n),
    .cal_request (calibration_request),
    .cal_go      (cal_go)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_st_q            <= adc_pin_pkg::CAL_DELAY;
      cal_cnt_q           <= '0;
      calibration_running <= 1'b0;
    end else begin
      case (cal_st_q)
        adc_pin_pkg::CAL_IDLE: begin
          if (cal_go) begin
            cal_st_q            <= adc_pin_pkg::CAL_RUN;
            cal_cnt_q           <= RUN_LEN;
            calibration_running <= 1'b1;
          end
        end
        adc_pin_pkg::CAL_DELAY: begin
          // Serial select steals the delay pin, so the short delay holds
          if (cal_cnt_q >= ((cal_delay_or_serial_select && !ext_now)
                            ? DLY_LONG : DLY_SHORT)) begin
            cal_st_q            <= adc_pin_pkg::CAL_RUN;
            cal_cnt_q           <= RUN_LEN;
            calibration_running <= 1'b1;
          end else begin
            cal_cnt_q <= cal_cnt_q + adc_pin_pkg::CNT_ONE;
          end
        end
        adc_pin_pkg::CAL_RUN: begin
          if (cal_cnt_q == adc_pin_pkg::CNT_ONE) begin
            cal_st_q            <= adc_pin_pkg::CAL_IDLE;
            cal_cnt_q           <= '0;
            calibration_running <= 1'b0;
          end else begin
            cal_cnt_q <= cal_cnt_q - adc_pin_pkg::CNT_ONE;
          end
        end
        default: begin
          cal_st_q            <= adc_pin_pkg::CAL_IDLE;
          cal_cnt_q           <= '0;
          calibration_running <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Capture buffer: fill once, then drain in pairs
  logic [7:0]              mem [DEPTH];
  adc_pin_pkg::cap_state_t cap_st_q;
  logic [AW-1:0]           wr_ptr_q;
  logic [AW-1:0]           rd_ptr_q;
  logic                    strobe_d;
  logic                    data_step;

  assign strobe_d  = !output_data_strobe;
  assign data_step = ddr_mode || (strobe_d == edge_rising);

  always_ff @(posedge clk) begin
    if (cap_st_q == adc_pin_pkg::CAP_FILL && sample_valid) begin
      mem[wr_ptr_q] <= {~sample_in[7], sample_in[6:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_st_q <= adc_pin_pkg::CAP_IDLE;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      case (cap_st_q)
        adc_pin_pkg::CAP_IDLE: begin
          if (capture_start) begin
            cap_st_q <= adc_pin_pkg::CAP_FILL;
            wr_ptr_q <= '0;
          end
        end
        adc_pin_pkg::CAP_FILL: begin
          if (sample_valid) begin
            wr_ptr_q <= wr_ptr_q + PTR_ONE;
            if (wr_ptr_q == PTR_LAST) begin
              cap_st_q <= adc_pin_pkg::CAP_DRAIN;
              rd_ptr_q <= '0;
            end
          end
        end
        adc_pin_pkg::CAP_DRAIN: begin
          if (data_step) begin
            rd_ptr_q <= rd_ptr_q + PTR_TWO;
            if (rd_ptr_q == PTR_PAIR_LAST) begin
              cap_st_q <= adc_pin_pkg::CAP_IDLE;
            end
          end
        end
        default: begin
          cap_st_q <= adc_pin_pkg::CAP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_data_strobe <= 1'b0;
      bus_a              <= '0;
      bus_b              <= '0;
      capture_busy       <= 1'b0;
    end else begin
      capture_busy <= (cap_st_q != adc_pin_pkg::CAP_IDLE) || capture_start;
      if (cap_st_q == adc_pin_pkg::CAP_DRAIN) begin
        output_data_strobe <= strobe_d;
        if (data_step) begin
          bus_a <= mem[rd_ptr_q];
          bus_b <= mem[rd_ptr_q + PTR_ONE];
        end
      end else begin
        output_data_strobe <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ext_mode_entry: assert property (ext_now |=> extended_mode)
    else $error("extended mode not entered on mid range pin");
  a_ddr_mid_level: assert property (
    (!ext_now && output_edge_select == adc_pin_pkg::LVL_MID)
    |=> ddr_mode)
    else $error("double rate not set on mid edge pin");
  a_edge_firm_level: assert property (
    (!ext_now && output_edge_select == adc_pin_pkg::LVL_HIGH)
    |=> edge_rising && !ddr_mode)
    else $error("edge select wrong for high edge pin");
  a_serial_shift: assert property (
    (serial_select_active && serial_rise
     && bit_cnt_q < adc_pin_pkg::FRAME_LEN)
    |=> bit_cnt_q == $past(bit_cnt_q) + FW'(1)
        && shift_q[0] == $past(serial_config_input))
    else $error("serial bit not shifted in");
  a_sync_single: assert property (
    (!config_word[adc_pin_pkg::SYNC_SRC_BIT]
     && sample_clock_sync_reset && !sync_src_prev_q)
    |=> sample_clock_reset && !sample_phase)
    else $error("single-ended reset pulse not honoured");
  a_sync_diff: assert property (
    (config_word[adc_pin_pkg::SYNC_SRC_BIT] && sample_clock_sync_reset
     && !sample_clock_sync_reset_pos) |=> !sample_clock_reset)
    else $error("single-ended reset used while pair selected");
  a_pd_follow: assert property (
    power_down_request |=> power_down_active)
    else $error("power down not entered");
  a_pd_capture: assert property (
    (cap_st_q == adc_pin_pkg::CAP_FILL && sample_valid
     && wr_ptr_q != PTR_LAST && power_down_active)
    |=> wr_ptr_q == $past(wr_ptr_q) + PTR_ONE)
    else $error("capture stalled in power down");
  a_offset_binary: assert property (
    (cap_st_q == adc_pin_pkg::CAP_FILL && sample_valid)
    |=> mem[$past(wr_ptr_q)] == {~$past(sample_in[7]),
                                 $past(sample_in[6:0])})
    else $error("stored sample not offset binary");
  a_cal_running: assert property (
    $rose(calibration_running) |-> calibration_running [*8])
    else $error("calibration running dropped early");
  a_cal_start: assert property (
    (cal_go && cal_st_q == adc_pin_pkg::CAL_IDLE)
    |=> calibration_running)
    else $error("calibration request not acted on");

  c_ddr_drain: cover property (
    ddr_mode && cap_st_q == adc_pin_pkg::CAP_DRAIN);
  c_config_write: cover property (
    $rose(config_word[adc_pin_pkg::SYNC_SRC_BIT]));
  c_sync_pulse: cover property (sample_clock_reset);

endmodule
`default_nettype wire

/* File: verif/host_pin_model.sv */
// Host model: serial configuration master and edge pin driver.
// Assumes send is raised at a falling edge while busy is low.
`timescale 1ns/10ps
`default_nettype none
module host_pin_model (
  input  wire logic        clk,
  input  wire logic        send,
  input  wire logic [4:0]  nbits,
  input  wire logic [19:0] word,
  input  wire logic [1:0]  idle_edge,
  output logic             serial_clock,
  output logic             select_n,
  output logic [1:0]       edge_pin,
  output logic             busy
);
  logic bit_q;

  // Edge pin carries frame data only while selected
  assign edge_pin = select_n ? idle_edge :
                    (bit_q ? adc_pin_pkg::LVL_HIGH : adc_pin_pkg::LVL_LOW);

  // ==========================================================
  // Frame engine, MSB first, clock still outside frames
  initial begin
    serial_clock = 1'b0;
    select_n     = 1'b1;
    bit_q        = 1'b0;
    busy         = 1'b0;
    forever begin
      @(posedge clk);
      if (send) begin
        busy = 1'b1;
        @(negedge clk);
        select_n = 1'b0;
        for (int k = 0; k < int'(nbits); k++) begin
          @(negedge clk);
          bit_q = word[19-k];
          @(negedge clk);
          serial_clock = 1'b1;
          @(negedge clk);
          serial_clock = 1'b0;
        end
        @(negedge clk);
        select_n = 1'b1;
        // Released data line must not keep its last bit
        bit_q    = ~bit_q;
        busy     = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the converter pin control logic.
// Assumes the host model owns the serial and edge pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int DEPTH = 16;
  localparam int DLY_S = 8;
  localparam int DLY_L = 16;
  localparam int RUN   = 10;

  logic        clk, rst_n, send, hbusy;
  logic [1:0]  output_edge_select, range_or_extended_enable, idle_edge;
  logic        cal_delay_or_serial_select, serial_clock;
  logic        sample_clock_sync_reset, sample_clock_sync_reset_pos;
  logic        sample_clock_sync_reset_neg, power_down_request;
  logic        calibration_request, sample_valid, capture_start;
  logic        extended_mode, edge_rising, ddr_mode, range_high;
  logic        power_down_active, calibration_running;
  logic        sample_clock_reset, sample_phase, capture_busy;
  logic        output_data_strobe;
  logic [7:0]  sample_in, bus_a, bus_b;
  logic [4:0]  nbits;
  logic [15:0] config_word;
  logic [19:0] word;
  int          fails, cmp_count;

  adc_control_pin_logic #(.DEPTH(DEPTH), .CAL_DLY_SHORT(DLY_S),
    .CAL_DLY_LONG(DLY_L), .CAL_RUN_CYCLES(RUN)) i_dut (
    .clk, .rst_n, .output_edge_select, .range_or_extended_enable,
    .cal_delay_or_serial_select, .serial_clock, .sample_clock_sync_reset,
    .sample_clock_sync_reset_pos, .sample_clock_sync_reset_neg,
    .power_down_request, .calibration_request, .sample_in, .sample_valid,
    .capture_start, .extended_mode, .edge_rising, .ddr_mode, .range_high,
    .power_down_active, .calibration_running, .sample_clock_reset,
    .sample_phase, .capture_busy, .output_data_strobe, .bus_a, .bus_b,
    .config_word);

  host_pin_model i_host (.clk, .send, .nbits, .word, .idle_edge,
    .serial_clock, .select_n(cal_delay_or_serial_select),
    .edge_pin(output_edge_select), .busy(hbusy));

  always #5 clk = ~clk;

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset, then time the power-up calibration window
  task automatic powerup(input int dly);
    int t, n;
    t = -1;
    n = 0;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int k = 0; k < 60; k++) begin
      @(negedge clk);
      if (calibration_running === 1'b1) begin
        if (t < 0) t = k;
        n++;
      end
    end
    check("cal delay", 16'h0001, 16'(t >= dly - 1 && t <= dly + 2));
    check("cal length", 16'(RUN), 16'(n));
    $display("test power-up done");
  endtask

  task automatic cal_try(input int lo, input int hi, input logic [15:0] exp);
    int t;
    t = -1;
    @(negedge clk);
    calibration_request = 1'b0;
    repeat (lo) @(negedge clk);
    calibration_request = 1'b1;
    for (int k = 0; k < 120; k++) begin
      @(negedge clk);
      if (k == hi) calibration_request = 1'b0;
      if (calibration_running === 1'b1 && t < 0) t = k;
    end
    calibration_request = 1'b1;
    check("cal start", exp, 16'(t >= 78 && t <= 82));
  endtask

  task automatic sync_try(input logic diff, input logic [15:0] exp);
    int seen;
    seen = 0;
    if (diff) begin
      sample_clock_sync_reset_pos = 1'b1;
      sample_clock_sync_reset_neg = 1'b0;
    end else begin
      sample_clock_sync_reset = 1'b1;
    end
    repeat (5) begin
      @(negedge clk);
      if (sample_clock_reset === 1'b1) begin
        seen++;
        check("sample_phase", 16'h0000, 16'(sample_phase));
      end
    end
    sample_clock_sync_reset     = 1'b0;
    sample_clock_sync_reset_pos = 1'b0;
    sample_clock_sync_reset_neg = 1'b1;
    repeat (2) @(negedge clk);
    check("sync pulses", exp, 16'(seen));
  endtask

  task automatic frame(input logic [4:0] n, input logic [19:0] w,
                       input logic [15:0] exp);
    nbits = n;
    word  = w;
    send  = 1'b1;
    @(negedge clk);
    send = 1'b0;
    for (int k = 0; k < 200 && hbusy !== 1'b0; k++) @(negedge clk);
    repeat (3) @(negedge clk);
    check("config_word", exp, config_word);
  endtask

  task automatic capture_run(input logic ddr, input logic rise);
    logic [15:0] last;
    logic [7:0]  e0, e1;
    int          np;
    // Buses still hold the previous run's last pair, or zeros after reset
    last = {bus_a, bus_b};
    np   = 0;
    power_down_request = 1'b1;
    capture_start      = 1'b1;
    @(negedge clk);
    capture_start = 1'b0;
    for (int k = 0; k < 5 && capture_busy !== 1'b1; k++) @(negedge clk);
    check("pd active", 16'h0001, 16'(power_down_active));
    for (int k = 0; k < DEPTH; k++) begin
      sample_in    = 8'(k * 17);
      sample_valid = 1'b1;
      @(negedge clk);
    end
    sample_valid = 1'b0;
    for (int k = 0; k < 200 && capture_busy === 1'b1; k++) begin
      // A start while draining must be ignored
      capture_start = (k == 2);
      @(negedge clk);
      if ({bus_a, bus_b} !== last && np < DEPTH / 2) begin
        e0 = 8'(np * 34) ^ 8'h80;
        e1 = 8'(np * 34 + 17) ^ 8'h80;
        check("bus pair", {e0, e1}, {bus_a, bus_b});
        if (!ddr) check("strobe at step", 16'(rise), 16'(output_data_strobe));
        last = {bus_a, bus_b};
        np++;
      end
    end
    capture_start = 1'b0;
    repeat (3) @(negedge clk);
    check("pairs", 16'(DEPTH / 2), 16'(np));
    check("busy after", 16'h0000, 16'(capture_busy));
    check("strobe idle", 16'h0000, 16'(output_data_strobe));
    $display("test capture done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    send = 1'b0;
    nbits = 5'h00;
    word = 20'h00000;
    idle_edge = adc_pin_pkg::LVL_LOW;
    range_or_extended_enable = adc_pin_pkg::LVL_LOW;
    sample_clock_sync_reset = 1'b0;
    sample_clock_sync_reset_pos = 1'b0;
    sample_clock_sync_reset_neg = 1'b1;
    power_down_request = 1'b0;
    calibration_request = 1'b1;
    sample_in = 8'h00;
    sample_valid = 1'b0;
    capture_start = 1'b0;
    fails = 0;
    cmp_count = 0;
    @(negedge clk);
    powerup(DLY_L);
    // Codes 0, 1, 2 are low, high and mid
    for (int k = 0; k < 3; k++) begin
      idle_edge = 2'(k);
      range_or_extended_enable = (k == 1) ? adc_pin_pkg::LVL_HIGH
                                          : adc_pin_pkg::LVL_LOW;
      power_down_request = (k == 1);
      repeat (3) @(negedge clk);
      if (k < 2) check("edge", 16'(k == 1), 16'(edge_rising));
      check("ddr", 16'(k == 2), 16'(ddr_mode));
      check("range", 16'(k == 1), 16'(range_high));
      check("pd", 16'(k == 1), 16'(power_down_active));
      check("ext", 16'h0000, 16'(extended_mode));
    end
    $display("test pin decode done");
    cal_try(40, 100, 16'h0000);
    cal_try(100, 40, 16'h0000);
    cal_try(80, 80, 16'h0001);
    $display("test calibration done");
    sync_try(1'b0, 16'h0001);
    sync_try(1'b1, 16'h0000);
    $display("test single sync done");
    range_or_extended_enable = adc_pin_pkg::LVL_MID;
    idle_edge = adc_pin_pkg::LVL_LOW;
    powerup(DLY_S);
    idle_edge = adc_pin_pkg::LVL_MID;
    repeat (3) @(negedge clk);
    check("ext", 16'h0001, 16'(extended_mode));
    check("ddr frozen", 16'h0000, 16'(ddr_mode));
    frame(5'h14, {4'h1, 16'h40A5}, 16'h40A5);
    frame(5'h14, {4'h2, 16'h1234}, 16'h40A5);
    frame(5'h13, {4'h1, 16'h0F0F}, 16'h40A5);
    $display("test serial done");
    sync_try(1'b1, 16'h0001);
    sync_try(1'b0, 16'h0000);
    $display("test pair sync done");
    capture_run(1'b0, 1'b0);
    // Back to normal mode: double rate, then rising-edge single rate
    range_or_extended_enable = adc_pin_pkg::LVL_LOW;
    idle_edge = adc_pin_pkg::LVL_MID;
    repeat (3) @(negedge clk);
    capture_run(1'b1, 1'b0);
    idle_edge = adc_pin_pkg::LVL_HIGH;
    repeat (3) @(negedge clk);
    capture_run(1'b0, 1'b1);
    summarize();
  end

  // Whole run needs about 1100 cycles
  initial begin
    #100000;
    fails++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize();
  end
endmodule
`default_nettype wire
